// ### core/lmd_decode.sv
// Long-mode instruction size decoder and control-transfer checker
`timescale 1ns/1ns
module lmd_decode
	import lmd_pkg::*;
#(
	parameter int DISP_W = 32
)(
	input wire logic CLK,
	input wire logic ARST_N,
	// Operating mode
	input wire logic LONG_ACTIVE,
	input wire logic CS_LONG,
	input wire logic CS_DEFAULT32,
	// Decoded instruction from fetch
	input wire logic INSN_VALID,
	input wire logic ESC_0F,
	input wire logic [7:0] OPCODE,
	input wire logic [1:0] MODRM_MOD,
	input wire logic [2:0] MODRM_REG,
	input wire logic [2:0] MODRM_RM,
	input wire logic REG_EXT_PRESENT,
	input wire logic REG_EXT_W,
	input wire logic [2:0] REG_EXT_RXB,
	input wire logic PFX_OPSIZE,
	input wire logic PFX_ADDRSIZE,
	input wire lmd_seg_t PFX_SEG,
	input wire logic [DISP_W-1:0] DISP,
	input wire logic [63:0] DISP_WIDE,
	input wire logic DISP_IS_WIDE,
	input wire logic [DISP_W-1:0] IMM,
	input wire logic [63:0] IMM_WIDE,
	input wire logic IMM_IS_WIDE,
	input wire logic [63:0] NEXT_IP,
	input wire logic [63:0] BASE_VAL,
	input wire logic [63:0] INDEX_VAL,
	input wire logic [1:0] SCALE,
	input wire logic HAS_BASE,
	input wire logic HAS_INDEX,
	input wire logic [63:0] AUX_F_BASE,
	input wire logic [63:0] AUX_G_BASE,
	// Fast call target registers
	input wire logic [63:0] LONG_CALL_TGT,
	input wire logic [63:0] COMPAT_CALL_TGT,
	input wire logic [31:0] LEGACY_CALL_TGT,
	// Register write-back
	input wire logic WB_VALID,
	input wire lmd_size_t WB_SIZE,
	input wire logic WB_BYTE,
	input wire logic [63:0] WB_DATA,
	input wire logic [63:0] WB_OLD,
	// Far transfer through a gate
	input wire logic GATE_VALID,
	input wire logic [3:0] GATE_TYPE,
	input wire logic [63:0] GATE_OFFSET,
	input wire logic TGT_CS_LONG,
	input wire logic TGT_CS_DEFAULT32,
	input wire logic PRIV_CHANGE,
	input wire logic [1:0] NEW_PRIV,
	input wire logic [63:0] TASK_BLOCK_SP,
	// Far return
	input wire logic FRET_VALID,
	input wire logic FRET_SS_NULL,
	input wire logic FRET_TGT_LONG,
	input wire logic [1:0] FRET_TGT_PRIV,
	// Decode results
	output logic DEC_VALID,
	output lmd_size_t DEC_OPSIZE,
	output lmd_size_t DEC_ADDRSIZE,
	output logic [3:0] DEC_REG_IDX,
	output logic [3:0] DEC_RM_IDX,
	output logic [63:0] DEC_IMM,
	output logic [63:0] DEC_LIN_ADDR,
	output logic DEC_STACK_OP,
	output logic DEC_NEAR_BRANCH,
	output logic DEC_UD_FAULT,
	output logic [63:0] DEC_FASTCALL_TGT,
	// Write-back result
	output logic WB_OUT_VALID,
	output logic [63:0] WB_OUT_DATA,
	// Gate transfer result
	output logic GATE_DONE,
	output logic GATE_GP_FAULT,
	output logic GATE_COMMIT,
	output logic [63:0] GATE_TARGET,
	output logic GATE_SWITCH_STACK,
	output logic [63:0] GATE_NEW_SP,
	output logic [15:0] GATE_NEW_SS,
	output logic GATE_PUSH_WIDE,
	output logic GATE_COPY_PARAMS,
	// Far return result
	output logic FRET_DONE,
	output logic FRET_GP_FAULT
);
	// Refuse widths the sign extension below cannot serve
	if (DISP_W < 8 || DISP_W > 32) begin : g_bad_disp_w
		$error("lmd_decode: DISP_W must lie in 8..32");
	end

	// Implicit stack-pointer users, near and far branches excluded
	function automatic logic is_stack_op(input logic esc, input logic [7:0] op,
		input logic [2:0] reg_f);
		logic r;
		r = 1'b0;
		if (esc) begin
			r = (op == OP_ESC_PUSH_AF) || (op == OP_ESC_POP_AF) ||
				(op == OP_ESC_PUSH_AG) || (op == OP_ESC_POP_AG);
		end else begin
			r = (op == OP_ENTER) || (op == OP_LEAVE) || (op == OP_PUSHF) ||
				(op == OP_POPF) || (op == OP_PUSH_IMM32) || (op == OP_PUSH_IMM8) ||
				(op[7:4] == 4'h5) || ((op == OP_POP_RM) && (reg_f == 3'h0)) ||
				((op == OP_GRP5) && (reg_f == GRP5_PUSH));
		end
		return r;
	endfunction

	// Near calls, jumps, conditional jumps, loops and near returns
	function automatic logic is_near_br(input logic esc, input logic [7:0] op,
		input logic [2:0] reg_f);
		logic r;
		r = 1'b0;
		if (esc) begin
			r = (op[7:4] == 4'h8);
		end else begin
			r = (op == OP_CALL_REL) || (op == OP_JMP_REL) || (op == OP_JMP_SHORT) ||
				(op == OP_RET) || (op == OP_RET_IMM) || (op[7:4] == 4'h7) ||
				(op[7:2] == 6'b111000 && op[1:0] != 2'h3) ||
				((op == OP_GRP5) && (reg_f == GRP5_CALL || reg_f == GRP5_JMP));
		end
		return r;
	endfunction

	// Sign extension of a short field to 64 bits
	function automatic logic [63:0] sext(input logic [DISP_W-1:0] v);
		return {{(64 - DISP_W){v[DISP_W-1]}}, v};
	endfunction

	logic mode64;
	logic stack_op;
	logic near_br;
	logic wide_move;
	logic ptr_rel;
	lmd_size_t next_opsize;
	lmd_size_t next_addrsize;
	lmd_size_t agen_size;
	logic [63:0] seg_base;
	logic [63:0] agen_base;
	logic [63:0] agen_index;
	logic [63:0] agen_disp;
	logic next_ud;
	logic [63:0] next_fastcall;

	assign mode64 = LONG_ACTIVE && CS_LONG;
	assign stack_op = is_stack_op(ESC_0F, OPCODE, MODRM_REG);
	assign near_br = is_near_br(ESC_0F, OPCODE, MODRM_REG);
	// Only the offset-move and register-immediate move forms carry wide fields
	assign wide_move = mode64 && !ESC_0F && (OPCODE[7:2] == 6'b101000 ||
		OPCODE[7:3] == 5'b10111); // see (RULE7)
	assign ptr_rel = mode64 && (MODRM_MOD == 2'h0) && (MODRM_RM == 3'h5);

	// Operand size; the extension prefix only matters through its W bit
	always_comb begin
		if (mode64) begin
			if (stack_op || near_br) begin
				// Reducible to 16 only; 32 never reachable here
				next_opsize = (PFX_OPSIZE && !REG_EXT_W) ? SZ16 : SZ64; // see (RULE10) (RULE11)
			end else if (REG_EXT_W) begin
				next_opsize = SZ64; // see (RULE2)
			end else begin
				next_opsize = PFX_OPSIZE ? SZ16 : SZ32; // see (RULE2)
			end
		end else begin
			next_opsize = (CS_DEFAULT32 ^ PFX_OPSIZE) ? SZ32 : SZ16;
		end
	end

	// Address size; in 64-bit code stack references ignore the address-size prefix
	always_comb begin
		if (mode64) begin
			next_addrsize = PFX_ADDRSIZE ? SZ32 : SZ64; // see (RULE6) (RULE12)
		end else begin
			next_addrsize = (CS_DEFAULT32 ^ PFX_ADDRSIZE) ? SZ32 : SZ16;
		end
		agen_size = (mode64 && stack_op) ? SZ64 : next_addrsize;
	end

	// Segment base; in 64-bit code the flat segments act as null prefixes
	always_comb begin
		case (PFX_SEG)
			SEG_AUX_F: seg_base = AUX_F_BASE; // see (RULE4)
			SEG_AUX_G: seg_base = AUX_G_BASE; // see (RULE4)
			default: seg_base = 64'h0; // see (RULE3)
		endcase
	end

	// Address operands for the adder
	always_comb begin
		agen_base = HAS_BASE ? BASE_VAL : 64'h0;
		agen_index = HAS_INDEX ? INDEX_VAL : 64'h0;
		if (ptr_rel) begin
			agen_base = NEXT_IP; // see (RULE9)
			agen_index = 64'h0;
		end
		// A wide displacement offered on any other form is ignored; DISP is sign-extended
		agen_disp = (DISP_IS_WIDE && wide_move) ? DISP_WIDE : sext(DISP); // see (RULE7)
	end

	// Invalid-opcode cases; an unused extension prefix never faults
	always_comb begin
		next_ud = 1'b0; // see (RULE1)
		if (mode64 && !ESC_0F && (OPCODE == OP_CALL_FAR_DIR || OPCODE == OP_JMP_FAR_DIR)) begin
			next_ud = 1'b1; // see (RULE18)
		end
		if (ESC_0F && OPCODE == OP_ESC_GRP7 && MODRM_MOD == 2'h3 &&
			MODRM_REG == GRP7_SWAP && MODRM_RM == 3'h0 && !mode64) begin
			next_ud = 1'b1; // see (RULE20)
		end
		if (LONG_ACTIVE && ESC_0F && (OPCODE == OP_ESC_ENTRY || OPCODE == OP_ESC_EXIT)) begin
			next_ud = 1'b1; // see (RULE21)
		end
	end

	// Fast call target: the legacy register keeps its 32-bit width
	always_comb begin
		if (!LONG_ACTIVE) begin
			next_fastcall = {32'h0, LEGACY_CALL_TGT};
		end else if (mode64) begin
			next_fastcall = LONG_CALL_TGT; // see (RULE19)
		end else begin
			next_fastcall = COMPAT_CALL_TGT; // see (RULE19)
		end
	end

	// Address adder, registered in step with the decode outputs
	lmd_agen u_agen (
		.clk(CLK),
		.arst_n(ARST_N),
		.en(INSN_VALID),
		.base(agen_base),
		.index(agen_index),
		.scale(SCALE),
		.disp(agen_disp),
		.seg_base(seg_base),
		.addr_sz(agen_size),
		.lin_trunc32(!mode64),
		.lin_addr(DEC_LIN_ADDR)
	);

	// Decode result registers; all but DEC_VALID held between valid instructions
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			DEC_VALID <= 1'b0;
			DEC_OPSIZE <= SZ32;
			DEC_ADDRSIZE <= SZ64;
			DEC_REG_IDX <= 4'h0;
			DEC_RM_IDX <= 4'h0;
			DEC_IMM <= 64'h0;
			DEC_STACK_OP <= 1'b0;
			DEC_NEAR_BRANCH <= 1'b0;
			DEC_UD_FAULT <= 1'b0;
			DEC_FASTCALL_TGT <= 64'h0;
		end else begin
			DEC_VALID <= INSN_VALID;
			if (INSN_VALID) begin
				DEC_OPSIZE <= next_opsize;
				DEC_ADDRSIZE <= agen_size;
				// Extension bits only reach the register index in 64-bit code
				DEC_REG_IDX <= {mode64 && REG_EXT_PRESENT && REG_EXT_RXB[2], MODRM_REG}; // see (RULE1)
				DEC_RM_IDX <= {mode64 && REG_EXT_PRESENT && REG_EXT_RXB[0], MODRM_RM}; // see (RULE1)
				DEC_IMM <= (IMM_IS_WIDE && wide_move && REG_EXT_W) ? IMM_WIDE : sext(IMM); // see (RULE7)
				DEC_STACK_OP <= mode64 && stack_op;
				DEC_NEAR_BRANCH <= near_br;
				DEC_UD_FAULT <= next_ud;
				DEC_FASTCALL_TGT <= next_fastcall;
			end
		end
	end

	// Write-back merge; byte and halfword writes keep untouched upper bits
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			WB_OUT_VALID <= 1'b0;
			WB_OUT_DATA <= 64'h0;
		end else begin
			WB_OUT_VALID <= WB_VALID;
			if (WB_VALID) begin
				if (WB_BYTE) begin
					WB_OUT_DATA <= {WB_OLD[63:8], WB_DATA[7:0]}; // see (RULE5)
				end else begin
					case (WB_SIZE)
						SZ16: WB_OUT_DATA <= {WB_OLD[63:16], WB_DATA[15:0]}; // see (RULE5)
						SZ32: WB_OUT_DATA <= {32'h0, WB_DATA[31:0]}; // see (RULE5)
						default: WB_OUT_DATA <= WB_DATA;
					endcase
				end
			end
		end
	end

	// Gate checks; a failed check suppresses every state-changing output
	logic gate_bad;
	assign gate_bad = LONG_ACTIVE && ((GATE_TYPE == GATE_TASK) || // see (RULE17)
		(GATE_TYPE != GATE_CALL64) || !TGT_CS_LONG || TGT_CS_DEFAULT32); // see (RULE13)

	// Gate transfer result, one cycle after the request
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			GATE_DONE <= 1'b0;
			GATE_GP_FAULT <= 1'b0;
			GATE_COMMIT <= 1'b0;
			GATE_TARGET <= 64'h0;
			GATE_SWITCH_STACK <= 1'b0;
			GATE_NEW_SP <= 64'h0;
			GATE_NEW_SS <= 16'h0;
			GATE_PUSH_WIDE <= 1'b0;
			GATE_COPY_PARAMS <= 1'b0;
		end else begin
			GATE_DONE <= GATE_VALID;
			GATE_GP_FAULT <= GATE_VALID && gate_bad; // see (RULE23)
			GATE_COMMIT <= GATE_VALID && !gate_bad; // see (RULE23)
			// Parameter copy is never offered in long mode
			GATE_COPY_PARAMS <= 1'b0; // see (RULE15)
			if (GATE_VALID && !gate_bad) begin
				// Target code-segment base plays no part in the target
				GATE_TARGET <= GATE_OFFSET; // see (RULE14)
				GATE_SWITCH_STACK <= PRIV_CHANGE;
				GATE_PUSH_WIDE <= LONG_ACTIVE; // see (RULE15)
				if (PRIV_CHANGE) begin
					GATE_NEW_SP <= TASK_BLOCK_SP; // see (RULE15)
					GATE_NEW_SS <= {14'h0, NEW_PRIV}; // see (RULE15)
				end
			end else begin
				GATE_SWITCH_STACK <= 1'b0;
			end
		end
	end

	// Far return: in long mode a null stack selector is legal only toward privileged 64-bit code
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			FRET_DONE <= 1'b0;
			FRET_GP_FAULT <= 1'b0;
		end else begin
			FRET_DONE <= FRET_VALID;
			FRET_GP_FAULT <= FRET_VALID && FRET_SS_NULL && LONG_ACTIVE &&
				!(FRET_TGT_LONG && FRET_TGT_PRIV < LVL_USER); // see (RULE16)
		end
	end
endmodule // lmd_decode

// ### core/lmd_pkg.sv
// Package with constants and types shared by the long-mode size decoder
// Notes on behaviour
// (RULE1) Unused register-extension prefix is ignored, no fault
// (RULE2) Operand default 32; extension 64; 66h 16
// (RULE3) Code/data/extra/stack overrides become null prefixes
// (RULE4) Auxiliary segment overrides add their base
// (RULE5) 32-bit write clears upper half; narrower preserve
// (RULE6) Address default 64; 67h gives 32; no 16
// (RULE7) Displacement/immediate 32, sign-extended; move forms excepted
// (RULE8) Truncate address sum, then zero-extend to 64
// (RULE9) Pointer-relative address is displacement plus next pointer
// (RULE10) Implicit stack ops default 64, reducible to 16
// (RULE11) Near branches default 64, reducible to 16
// (RULE12) Near-branch address 64 or 32; displacement 32
// (RULE13) Long-mode gate must be 64-bit, 64-bit target
// (RULE14) Gate target from gate, code base ignored
// (RULE15) Gate stack switch: wide pointer, null selector
// (RULE16) Far return null selector: 64-bit target, level<3
// (RULE17) Task-gate transfers refused in long mode
// (RULE18) Direct far branches invalid in 64-bit sub-mode
// (RULE19) Fast call target from long or compat register
// (RULE20) Swap instruction only valid in 64-bit sub-mode
// (RULE21) Legacy fast entry/exit fault in long mode
// (RULE22) Software uses fast call/return in long mode
// (RULE23) Bad gate aborts with protection fault, no state
package lmd_pkg;
	typedef logic [1:0] lmd_size_t;
	localparam lmd_size_t SZ16 = 2'h0;
	localparam lmd_size_t SZ32 = 2'h1;
	localparam lmd_size_t SZ64 = 2'h2;

	typedef logic [2:0] lmd_seg_t;
	localparam lmd_seg_t SEG_NONE = 3'h0;
	localparam lmd_seg_t SEG_EXTRA = 3'h1;
	localparam lmd_seg_t SEG_CODE = 3'h2;
	localparam lmd_seg_t SEG_STACK = 3'h3;
	localparam lmd_seg_t SEG_DATA = 3'h4;
	localparam lmd_seg_t SEG_AUX_F = 3'h5;
	localparam lmd_seg_t SEG_AUX_G = 3'h6;

	// Opcode bytes that the decoder classifies
	localparam logic [7:0] OP_ENTER = 8'hC8;
	localparam logic [7:0] OP_LEAVE = 8'hC9;
	localparam logic [7:0] OP_POP_RM = 8'h8F;
	localparam logic [7:0] OP_PUSH_IMM32 = 8'h68;
	localparam logic [7:0] OP_PUSH_IMM8 = 8'h6A;
	localparam logic [7:0] OP_PUSHF = 8'h9C;
	localparam logic [7:0] OP_POPF = 8'h9D;
	localparam logic [7:0] OP_GRP5 = 8'hFF;
	localparam logic [7:0] OP_CALL_REL = 8'hE8;
	localparam logic [7:0] OP_JMP_REL = 8'hE9;
	localparam logic [7:0] OP_JMP_SHORT = 8'hEB;
	localparam logic [7:0] OP_RET = 8'hC3;
	localparam logic [7:0] OP_RET_IMM = 8'hC2;
	localparam logic [7:0] OP_CALL_FAR_DIR = 8'h9A;
	localparam logic [7:0] OP_JMP_FAR_DIR = 8'hEA;
	localparam logic [7:0] OP_ESC_GRP7 = 8'h01;
	localparam logic [7:0] OP_ESC_FASTCALL = 8'h05;
	localparam logic [7:0] OP_ESC_ENTRY = 8'h34;
	localparam logic [7:0] OP_ESC_EXIT = 8'h35;
	localparam logic [7:0] OP_ESC_PUSH_AF = 8'hA0;
	localparam logic [7:0] OP_ESC_POP_AF = 8'hA1;
	localparam logic [7:0] OP_ESC_PUSH_AG = 8'hA8;
	localparam logic [7:0] OP_ESC_POP_AG = 8'hA9;
	localparam logic [2:0] GRP5_CALL = 3'h2;
	localparam logic [2:0] GRP5_JMP = 3'h4;
	localparam logic [2:0] GRP5_PUSH = 3'h6;
	localparam logic [2:0] GRP7_SWAP = 3'h7;

	// Gate descriptor type codes; plain defaults, adjust to the descriptor unit
	localparam logic [3:0] GATE_CALL64 = 4'hC;
	localparam logic [3:0] GATE_TASK = 4'h5;
	localparam logic [1:0] LVL_USER = 2'h3;
endpackage

// ### core/lmd_agen.sv
// Address adder: sum, truncation to address size, zero extension, segment base
`timescale 1ns/1ns
module lmd_agen
	import lmd_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic en,
	input wire logic [63:0] base,
	input wire logic [63:0] index,
	input wire logic [1:0] scale,
	input wire logic [63:0] disp,
	input wire logic [63:0] seg_base,
	input wire lmd_size_t addr_sz,
	input wire logic lin_trunc32,
	output logic [63:0] lin_addr
);
	logic [63:0] sum;
	logic [63:0] ea;
	logic [63:0] lin;

	// Raw sum wraps at 64 bits before it is cut to the address size
	always_comb begin
		sum = base + (index << scale) + disp;
		case (addr_sz)
			SZ16: ea = {48'h0, sum[15:0]}; // see (RULE8)
			SZ32: ea = {32'h0, sum[31:0]}; // see (RULE8)
			default: ea = sum;
		endcase
		lin = ea + seg_base; // see (RULE4)
		// Compatibility code sees only the low half of an auxiliary base
		if (lin_trunc32) begin
			lin = {32'h0, lin[31:0]};
		end
	end

	// Result register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lin_addr <= 64'h0;
		end else if (en) begin
			lin_addr <= lin;
		end
	end
endmodule // lmd_agen

// ### verification/lmd_fetch_model.sv
// Fetch-path model that hands the decoder one prefixed instruction at a time
`timescale 1ns/1ns
module lmd_fetch_model (
	input wire logic clk,
	output logic valid,
	output logic esc,
	output logic [7:0] op,
	output logic [1:0] md,
	output logic [2:0] rg,
	output logic [2:0] rm,
	output logic rex_p,
	output logic rex_w,
	output logic p66,
	output logic p67,
	output lmd_pkg::lmd_seg_t seg
);
	import lmd_pkg::*;
	// Idle until the first request
	initial begin
		valid = 1'b0;
		{esc, op, md, rg, rm, rex_p, rex_w, p66, p67, seg} = 24'h0;
	end
	// One cycle per instruction; the fields are inverted afterwards so that
	// a decoder reading them outside the valid cycle shows up
	task automatic issue(input logic [23:0] f);
		@(negedge clk);
		valid = 1'b1;
		{esc, op, md, rg, rm, rex_p, rex_w, p66, p67, seg} = f;
		@(negedge clk);
		valid = 1'b0;
		{esc, op, md, rg, rm, rex_p, rex_w, p66, p67, seg} = ~f;
	endtask
endmodule // lmd_fetch_model

// ### verification/lmd_decode_sva.sv
// Concurrent checks on the ports of the long-mode size decoder
`timescale 1ns/1ns
module lmd_decode_sva (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic LONG_ACTIVE,
	input wire logic CS_LONG,
	input wire logic INSN_VALID,
	input wire logic ESC_0F,
	input wire logic [7:0] OPCODE,
	input wire logic REG_EXT_W,
	input wire logic WB_VALID,
	input wire logic WB_BYTE,
	input wire lmd_pkg::lmd_size_t WB_SIZE,
	input wire logic [63:0] WB_DATA,
	input wire logic WB_OUT_VALID,
	input wire logic [63:0] WB_OUT_DATA,
	input wire logic GATE_VALID,
	input wire logic [3:0] GATE_TYPE,
	input wire logic TGT_CS_LONG,
	input wire logic GATE_DONE,
	input wire logic GATE_GP_FAULT,
	input wire logic GATE_COMMIT,
	input wire logic [63:0] GATE_TARGET,
	input wire logic GATE_SWITCH_STACK,
	input wire logic GATE_COPY_PARAMS,
	input wire logic FRET_VALID,
	input wire logic FRET_SS_NULL,
	input wire logic [1:0] FRET_TGT_PRIV,
	input wire logic FRET_DONE,
	input wire logic FRET_GP_FAULT,
	input wire lmd_pkg::lmd_size_t DEC_OPSIZE,
	input wire lmd_pkg::lmd_size_t DEC_ADDRSIZE,
	input wire logic DEC_UD_FAULT
);
	import lmd_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	logic m64;
	// 64-bit sub-mode qualifier shared by the decode checks
	assign m64 = LONG_ACTIVE && CS_LONG;
	a_wide_opsize: assert property (INSN_VALID && m64 && REG_EXT_W |=> DEC_OPSIZE == SZ64)
		else $error("opsize not 64 under W");
	a_addr_no16: assert property (INSN_VALID && m64 |=> DEC_ADDRSIZE != SZ16)
		else $error("16-bit address in 64-bit mode");
	a_far_direct: assert property (INSN_VALID && m64 && !ESC_0F
		&& (OPCODE == OP_CALL_FAR_DIR || OPCODE == OP_JMP_FAR_DIR) |=> DEC_UD_FAULT)
		else $error("direct far branch accepted");
	a_fast_legacy: assert property (INSN_VALID && LONG_ACTIVE && ESC_0F
		&& (OPCODE == OP_ESC_ENTRY || OPCODE == OP_ESC_EXIT) |=> DEC_UD_FAULT)
		else $error("legacy fast entry accepted");
	a_wb_zero_upper: assert property (WB_VALID && !WB_BYTE && WB_SIZE == SZ32
		|=> WB_OUT_VALID && WB_OUT_DATA == ($past(WB_DATA) & 64'h0000_0000_FFFF_FFFF))
		else $error("32-bit write not zero-extended");
	a_task_refused: assert property (GATE_VALID && LONG_ACTIVE && GATE_TYPE == GATE_TASK
		|=> GATE_DONE && GATE_GP_FAULT && !GATE_COMMIT)
		else $error("task gate not refused");
	// A gate refused for a non-long target segment must leave the target and stack switch alone
	a_gate_no_state: assert property (GATE_VALID && LONG_ACTIVE && !TGT_CS_LONG
		|=> GATE_GP_FAULT && $stable(GATE_TARGET) && !GATE_SWITCH_STACK)
		else $error("bad gate changed state");
	a_no_param_copy: assert property (GATE_DONE |-> !GATE_COPY_PARAMS)
		else $error("parameter copy requested");
	a_fret_user_null: assert property (FRET_VALID && FRET_SS_NULL && LONG_ACTIVE
		&& FRET_TGT_PRIV == LVL_USER |=> FRET_DONE && FRET_GP_FAULT)
		else $error("null stack to user accepted");
	c_gate_fault: cover property (GATE_DONE && GATE_GP_FAULT);
	c_gate_switch: cover property (GATE_DONE && GATE_COMMIT && GATE_SWITCH_STACK);
	c_ud: cover property (INSN_VALID ##1 DEC_UD_FAULT);
endmodule // lmd_decode_sva
bind lmd_decode lmd_decode_sva u_sva (.*);

// ### verification/test_long_mode_insn_size_decode.sv
// Self-checking bench for the long-mode size decoder
`timescale 1ns/1ns
module test_long_mode_insn_size_decode;
	import lmd_pkg::*;
	logic CLK = 1'b0, ARST_N = 1'b0, LONG_ACTIVE = 1'b1, CS_LONG = 1'b1, CS_DEFAULT32 = 1'b0;
	logic INSN_VALID, ESC_0F, REG_EXT_PRESENT, REG_EXT_W, PFX_OPSIZE, PFX_ADDRSIZE;
	logic [7:0] OPCODE;
	logic [1:0] MODRM_MOD, SCALE = 2'h0, NEW_PRIV = 2'h1, FRET_TGT_PRIV = 2'h0;
	logic [2:0] MODRM_REG, MODRM_RM, REG_EXT_RXB = 3'h5;
	lmd_seg_t PFX_SEG;
	logic [31:0] DISP = 32'h20, IMM = 32'h0, LEGACY_CALL_TGT = 32'hC000;
	logic [63:0] DISP_WIDE = 64'h5A5A, IMM_WIDE = 64'h3C3C, INDEX_VAL = 64'h0;
	logic [63:0] NEXT_IP = 64'h7FFF_0000_0000_0100, BASE_VAL = 64'h1_FFFF_FFF0;
	logic [63:0] AUX_F_BASE = 64'h1000_0000_0000, AUX_G_BASE = 64'h2000_0000_0000;
	logic [63:0] LONG_CALL_TGT = 64'hFFFF_8000_0000_1000, COMPAT_CALL_TGT = 64'h40_2000;
	logic [63:0] WB_DATA = 64'h1122_3344_5566_7788, WB_OLD = 64'hAAAA_BBBB_CCCC_DDDD;
	logic [63:0] GATE_OFFSET = 64'h0, TASK_BLOCK_SP = 64'hFFFF_C000_0000_0F00, tgt = 64'h0;
	logic DISP_IS_WIDE = 1'b0, IMM_IS_WIDE = 1'b0, HAS_BASE = 1'b1, HAS_INDEX = 1'b0;
	logic WB_VALID = 1'b0, WB_BYTE = 1'b0, GATE_VALID = 1'b0, TGT_CS_LONG = 1'b1;
	logic TGT_CS_DEFAULT32 = 1'b0, PRIV_CHANGE = 1'b0, FRET_VALID = 1'b0, FRET_SS_NULL = 1'b0;
	logic FRET_TGT_LONG = 1'b1;
	lmd_size_t WB_SIZE = SZ64, DEC_OPSIZE, DEC_ADDRSIZE;
	logic DEC_VALID, DEC_STACK_OP, DEC_NEAR_BRANCH, DEC_UD_FAULT, WB_OUT_VALID, GATE_DONE;
	logic GATE_GP_FAULT, GATE_COMMIT, GATE_SWITCH_STACK, GATE_PUSH_WIDE, GATE_COPY_PARAMS;
	logic FRET_DONE, FRET_GP_FAULT;
	logic [3:0] DEC_REG_IDX, DEC_RM_IDX, GATE_TYPE = 4'h0;
	logic [63:0] DEC_IMM, DEC_LIN_ADDR, DEC_FASTCALL_TGT, WB_OUT_DATA, GATE_TARGET, GATE_NEW_SP;
	logic [15:0] GATE_NEW_SS;
	int errors = 0, comparisons = 0;
	lmd_fetch_model u_fetch (.clk(CLK), .valid(INSN_VALID), .esc(ESC_0F), .op(OPCODE),
		.md(MODRM_MOD), .rg(MODRM_REG), .rm(MODRM_RM), .rex_p(REG_EXT_PRESENT),
		.rex_w(REG_EXT_W), .p66(PFX_OPSIZE), .p67(PFX_ADDRSIZE), .seg(PFX_SEG));
	lmd_decode DUT (.*);
	always #2 CLK = ~CLK;
	task automatic conclude();
		if (errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// Plain opcode; f is {extension present, W, 66h, 67h}
	task automatic dec(input logic [7:0] op, input logic [1:0] md, input logic [2:0] rm,
			input logic [3:0] f, input lmd_seg_t sg);
		u_fetch.issue({1'b0, op, md, 3'h0, rm, f, sg});
	endtask
	task automatic t_opsize();
		logic [7:0] ops [3] = '{8'h01, 8'h50, OP_CALL_REL};
		lmd_size_t e;
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 4; i++) begin
				dec(ops[k], 2'h3, 3'h0, {1'b1, i[1], i[0], 1'b0}, SEG_NONE);
				e = (k == 0) ? (i[1] ? SZ64 : i[0] ? SZ16 : SZ32) : (i == 1 ? SZ16 : SZ64);
				chk("opsize", 64'(e), 64'(DEC_OPSIZE));
				chk("ud", 64'h0, 64'(DEC_UD_FAULT));
				chk("valid", 64'h1, 64'(DEC_VALID));
				chk("stack", 64'(k == 1), 64'(DEC_STACK_OP));
			end
		end
		chk("branch", 64'h1, 64'(DEC_NEAR_BRANCH));
		// Extension bits reach both register indices in 64-bit code
		chk("reg", 64'h8, 64'(DEC_REG_IDX));
		chk("rm", 64'h8, 64'(DEC_RM_IDX));
	endtask
	task automatic t_addr();
		for (int s = 1; s < 5; s++) begin
			dec(8'h8B, 2'h2, 3'h0, 4'h1, lmd_seg_t'(s));
			chk("lin", 64'h10, DEC_LIN_ADDR);
			chk("asz", 64'(SZ32), 64'(DEC_ADDRSIZE));
		end
		dec(8'h8B, 2'h2, 3'h0, 4'h0, SEG_NONE);
		chk("lin", 64'h2_0000_0010, DEC_LIN_ADDR);
		// Wide offers on a form that may not take them must be ignored
		DISP = 32'hFFFF_FFF0;
		DISP_IS_WIDE = 1'b1;
		IMM = 32'h8000_0000;
		IMM_IS_WIDE = 1'b1;
		INDEX_VAL = 64'h4;
		SCALE = 2'h2;
		HAS_INDEX = 1'b1;
		dec(8'h8B, 2'h2, 3'h0, 4'hC, SEG_AUX_F);
		chk("lin", 64'h1001_FFFF_FFF0, DEC_LIN_ADDR);
		chk("imm", 64'hFFFF_FFFF_8000_0000, DEC_IMM);
		dec(8'h8B, 2'h2, 3'h0, 4'h0, SEG_AUX_G);
		chk("lin", 64'h2001_FFFF_FFF0, DEC_LIN_ADDR);
		dec(8'h8B, 2'h0, 3'h5, 4'h0, SEG_NONE);
		chk("lin", 64'h7FFF_0000_0000_00F0, DEC_LIN_ADDR);
		dec(OP_CALL_REL, 2'h3, 3'h0, 4'h1, SEG_NONE);
		chk("asz", 64'(SZ32), 64'(DEC_ADDRSIZE));
		// Offset-move form takes both wide fields as offered
		HAS_BASE = 1'b0;
		HAS_INDEX = 1'b0;
		dec(8'hA0, 2'h0, 3'h0, 4'hC, SEG_NONE);
		chk("lin", 64'h5A5A, DEC_LIN_ADDR);
		chk("imm", 64'h3C3C, DEC_IMM);
	endtask
	task automatic ud(input logic la, input logic cl, input logic es, input logic [7:0] op,
			input logic [2:0] rg, input logic e);
		LONG_ACTIVE = la;
		CS_LONG = cl;
		u_fetch.issue({es, op, 2'h3, rg, 3'h0, 4'h0, SEG_NONE});
		chk("ud", 64'(e), 64'(DEC_UD_FAULT));
		chk("tgt", !la ? {32'h0, LEGACY_CALL_TGT} : cl ? LONG_CALL_TGT : COMPAT_CALL_TGT,
			DEC_FASTCALL_TGT);
	endtask
	task automatic t_ud();
		ud(1'b1, 1'b1, 1'b0, OP_CALL_FAR_DIR, 3'h0, 1'b1);
		ud(1'b1, 1'b1, 1'b0, OP_JMP_FAR_DIR, 3'h0, 1'b1);
		ud(1'b1, 1'b0, 1'b0, OP_JMP_FAR_DIR, 3'h0, 1'b0);
		ud(1'b1, 1'b0, 1'b1, OP_ESC_GRP7, GRP7_SWAP, 1'b1);
		ud(1'b0, 1'b0, 1'b1, OP_ESC_GRP7, GRP7_SWAP, 1'b1);
		ud(1'b1, 1'b0, 1'b1, OP_ESC_ENTRY, 3'h0, 1'b1);
		ud(1'b0, 1'b0, 1'b1, OP_ESC_ENTRY, 3'h0, 1'b0);
		ud(1'b1, 1'b1, 1'b1, OP_ESC_EXIT, 3'h0, 1'b1);
		ud(1'b1, 1'b1, 1'b1, OP_ESC_GRP7, GRP7_SWAP, 1'b0);
		// Long-mode programs enter the kernel through the fast call instead
		ud(1'b1, 1'b1, 1'b1, OP_ESC_FASTCALL, 3'h0, 1'b0);
		ud(1'b1, 1'b0, 1'b1, OP_ESC_FASTCALL, 3'h0, 1'b0);
	endtask
	task automatic wb(input logic b, input lmd_size_t s, input logic [63:0] e);
		@(negedge CLK);
		WB_VALID = 1'b1;
		WB_BYTE = b;
		WB_SIZE = s;
		@(negedge CLK);
		WB_VALID = 1'b0;
		chk("wb", e, WB_OUT_DATA);
	endtask
	task automatic t_wb();
		wb(1'b1, SZ64, 64'hAAAA_BBBB_CCCC_DD88);
		wb(1'b0, SZ16, 64'hAAAA_BBBB_CCCC_7788);
		wb(1'b0, SZ32, 64'h5566_7788);
	endtask
	// Each request carries a fresh offset so a stale or leaked target shows
	task automatic gate(input logic [3:0] ty, input logic tl, input logic td, input logic pc,
			input logic bad);
		@(negedge CLK);
		GATE_VALID = 1'b1;
		GATE_TYPE = ty;
		TGT_CS_LONG = tl;
		TGT_CS_DEFAULT32 = td;
		PRIV_CHANGE = pc;
		GATE_OFFSET = GATE_OFFSET + 64'hFFFF_0000_1111;
		@(negedge CLK);
		GATE_VALID = 1'b0;
		if (!bad) tgt = GATE_OFFSET;
		chk("gp", 64'(bad), 64'(GATE_GP_FAULT));
		chk("target", tgt, GATE_TARGET);
		chk("switch", 64'(pc && !bad), 64'(GATE_SWITCH_STACK));
		if (pc && !bad) begin
			chk("sp", TASK_BLOCK_SP, GATE_NEW_SP);
			chk("ss", 64'(NEW_PRIV), 64'(GATE_NEW_SS));
			chk("wide", 64'h1, 64'(GATE_PUSH_WIDE));
		end
	endtask
	task automatic t_gate();
		gate(GATE_CALL64, 1'b1, 1'b0, 1'b1, 1'b0);
		gate(GATE_TASK, 1'b1, 1'b0, 1'b0, 1'b1);
		gate(4'h4, 1'b1, 1'b0, 1'b1, 1'b1);
		gate(GATE_CALL64, 1'b0, 1'b0, 1'b1, 1'b1);
		gate(GATE_CALL64, 1'b1, 1'b1, 1'b0, 1'b1);
		gate(GATE_CALL64, 1'b1, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic fret(input logic n, input logic tl, input logic [1:0] p, input logic e);
		@(negedge CLK);
		FRET_VALID = 1'b1;
		FRET_SS_NULL = n;
		FRET_TGT_LONG = tl;
		FRET_TGT_PRIV = p;
		@(negedge CLK);
		FRET_VALID = 1'b0;
		chk("fret", 64'(e), 64'(FRET_GP_FAULT));
	endtask
	task automatic t_fret();
		fret(1'b1, 1'b1, 2'h2, 1'b0);
		fret(1'b1, 1'b1, 2'h3, 1'b1);
		fret(1'b1, 1'b0, 2'h0, 1'b1);
		fret(1'b0, 1'b1, 2'h3, 1'b0);
	endtask
	// Main sequence: reset for two cycles, then every scenario in turn
	initial begin
		repeat (2) @(negedge CLK);
		chk("rst", 64'(SZ32), 64'(DEC_OPSIZE));
		ARST_N = 1'b1;
		t_opsize();
		t_addr();
		t_ud();
		t_wb();
		t_gate();
		t_fret();
		conclude();
	end
	// Watchdog: the scenarios need well under a microsecond
	initial begin
		#4000;
		errors++;
		conclude();
	end
endmodule // test_long_mode_insn_size_decode
